// ### design/dpsds_top.sv
// dpll state sequencing, lock flags and dco steering, apb slave
// assumes reference/xo qualifier inputs arrive from other clock domains
`timescale 1ns/1ps
`default_nettype none
// Operation
// - decode two three-level straps into start-up page zero to eight
// - with overlay enabled, load page then overwrite analog numerator
// - invalid dpll config keeps analog pll locked to crystal
// - analog pll locks to valid crystal; references unqualified in free-run
// - reference lost before history valid goes to free-run
// - any valid input leaves free-run or holdover into acquisition
// - wide loop bandwidth during acquisition, normal afterwards
// - frequency and phase lock loss flags as status bits and pins
// - history accumulates once frequency lock loss falls, if enabled
// - reference loss with history valid enters holdover
// - holdover without history uses free-run word over numerator
// - history enabled but invalid uses free-run word; valid uses average
// - holdover sets phase lock loss, freezes frequency lock loss
// - valid input in holdover leads to glitchless relock
// - steering alters dpll numerator when closed loop, else analog
// - steering enabled while locked; steps, pins or direct numerator
// - 38-bit deviation added or subtracted from feedback numerator
// - step-update write of 0 increases, 1 decreases
// - trigger pin rising edge steps; direction pin 1 decreases
// - clearing steering enable restores original feedback numerator
// - analog steering relative with history, not applied without; readable
module dpsds_top
  import dpsds_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  page_strap_a,
  input  wire logic [1:0]  page_strap_b,
  input  wire logic        overlay_enable,
  input  wire logic        xo_valid,
  input  wire logic        ref_valid,
  input  wire logic        freq_in_tol,
  input  wire logic        phase_in_tol,
  input  wire logic        freq_step_up,
  input  wire logic        freq_step_down,
  output logic             freq_lock_lost,
  output logic             phase_lock_lost,
  output logic             wide_bw,
  output logic             apll_on_xo,
  output logic [3:0]       boot_page,
  output logic [39:0]      eff_dpll_num,
  output logic [39:0]      feedback_numerator
);
  // freq_step_up is the trigger pin, freq_step_down the direction pin
  logic [2:0]  sy_a_reg, sy_b_reg;
  logic [3:0]  pin_sync1_reg, pin_sync2_reg;
  logic        trig_d_reg;
  logic [31:0] ctrl_reg;
  logic [37:0] step_deviation_word;
  logic [39:0] holdover_freq_word;
  logic [39:0] fb_base_reg;
  logic [39:0] fb_next;
  logic [39:0] anum_base_reg;
  logic [39:0] effective_analog_numerator;
  logic [39:0] hist_acc_reg;
  logic [15:0] hist_cnt_reg, acq_cnt_reg, pl_cnt_reg;
  logic        history_valid;
  logic        boot_done, boot_seen_reg;
  logic [3:0]  strap_page;
  dpsds_state_t  state_reg;
  dpsds_status_t stat;
  logic wr, rd, known;
  logic xo_ok, ref_ok, fit, pit, trig, dir;
  logic step_pin, step_reg_wr, step_dec, do_step;
  logic history_enable, steering_enable, pin_mode, dpll_cfg, dpll_used;
  logic closed_loop;

  assign history_enable  = ctrl_reg[CTRL_HIST_EN];
  assign steering_enable = ctrl_reg[CTRL_STEER_EN];
  assign pin_mode        = ctrl_reg[CTRL_PIN_MODE];
  assign dpll_cfg        = ctrl_reg[CTRL_DPLL_CFG];
  assign dpll_used       = ctrl_reg[CTRL_DPLL_USED];

  dpsds_strap u_strap (
    .pclk        (pclk),
    .presetn     (presetn),
    .strap_a_raw (page_strap_a),
    .strap_b_raw (page_strap_b),
    .done        (boot_done),
    .page        (strap_page)
  );
  assign boot_page = strap_page;

  // two-flop synchronisers on every asynchronous status/pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1_reg <= 4'h0;
      pin_sync2_reg <= 4'h0;
      sy_a_reg      <= 3'h0;
      sy_b_reg      <= 3'h0;
    end else begin
      pin_sync1_reg <= {freq_step_up, freq_step_down, xo_valid, ref_valid};
      pin_sync2_reg <= pin_sync1_reg;
      sy_a_reg      <= {freq_in_tol, phase_in_tol, 1'b0};
      sy_b_reg      <= sy_a_reg;
    end
  end
  assign trig   = pin_sync2_reg[3];
  assign dir    = pin_sync2_reg[2];
  assign xo_ok  = pin_sync2_reg[1];
  assign ref_ok = pin_sync2_reg[0] && dpll_cfg;
  assign fit    = sy_b_reg[2];
  assign pit    = sy_b_reg[1];

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign pready = 1'b1;

  function automatic logic is_known(input logic [7:0] a);
    is_known = (a <= OFF_ENUM_HI) && (a[1:0] == 2'b00);
  endfunction
  assign known   = is_known(paddr);
  assign pslverr = psel && penable && !known;

  // dpll operating state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= DPSDS_ST_FREE;
      acq_cnt_reg <= 16'h0;
    end else begin
      case (state_reg)
        DPSDS_ST_FREE: begin
          if (ref_ok && xo_ok) begin
            state_reg   <= DPSDS_ST_ACQ;
            acq_cnt_reg <= 16'h0;
          end
        end
        DPSDS_ST_ACQ: begin
          if (!ref_ok) begin
            state_reg <= history_valid ? DPSDS_ST_HOLD : DPSDS_ST_FREE;
          end else if (acq_cnt_reg == ACQ_CYCLES - 16'h1) begin
            state_reg <= DPSDS_ST_LOCK;
          end else begin
            acq_cnt_reg <= acq_cnt_reg + 16'h1;
          end
        end
        DPSDS_ST_LOCK: begin
          if (!ref_ok) begin
            state_reg <= history_valid ? DPSDS_ST_HOLD : DPSDS_ST_FREE;
          end
        end
        DPSDS_ST_HOLD: begin
          if (ref_ok) begin
            state_reg   <= DPSDS_ST_ACQ;
            acq_cnt_reg <= 16'h0;
          end
        end
        default: state_reg <= DPSDS_ST_FREE;
      endcase
    end
  end
  assign wide_bw = (state_reg == DPSDS_ST_ACQ);
  // analog loop follows xo in free-run or when the dpll config is invalid
  assign apll_on_xo = xo_ok && (state_reg == DPSDS_ST_FREE
                      || !dpll_cfg);

  // lock detectors; phase detector needs a clean window of samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_lock_lost  <= 1'b1;
      phase_lock_lost <= 1'b1;
      pl_cnt_reg      <= 16'h0;
    end else if (state_reg == DPSDS_ST_HOLD) begin
      phase_lock_lost <= 1'b1;
      pl_cnt_reg      <= 16'h0;
    end else if (state_reg == DPSDS_ST_FREE) begin
      freq_lock_lost  <= 1'b1;
      phase_lock_lost <= 1'b1;
      pl_cnt_reg      <= 16'h0;
    end else begin
      // no reference, nothing to compare: keep the flag as it was
      if (ref_ok) begin
        freq_lock_lost <= !fit;
      end
      if (!pit) begin
        pl_cnt_reg      <= 16'h0;
        phase_lock_lost <= 1'b1;
      end else if (pl_cnt_reg == PLOCK_CYCLES - 16'h1) begin
        phase_lock_lost <= 1'b0;
      end else begin
        pl_cnt_reg <= pl_cnt_reg + 16'h1;
      end
    end
  end

  // tuning-word history: running average of the effective numerator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_acc_reg  <= 40'h0;
      hist_cnt_reg  <= 16'h0;
      history_valid <= 1'b0;
    end else if (!history_enable || state_reg == DPSDS_ST_FREE) begin
      hist_cnt_reg  <= 16'h0;
      history_valid <= 1'b0;
    end else if (state_reg == DPSDS_ST_LOCK && !freq_lock_lost) begin
      hist_acc_reg <= hist_acc_reg - (hist_acc_reg >>> 4)
                      + (eff_dpll_num >>> 4);
      if (hist_cnt_reg == HIST_CYCLES - 16'h1) begin
        history_valid <= 1'b1;
      end else begin
        hist_cnt_reg <= hist_cnt_reg + 16'h1;
      end
    end
  end

  // step sources
  assign step_pin    = pin_mode && trig && !trig_d_reg;
  assign step_reg_wr = !pin_mode && wr && paddr == OFF_STEP;
  assign step_dec    = step_pin ? dir : pwdata[0];
  assign closed_loop = dpll_used && state_reg == DPSDS_ST_LOCK;
  // pin timing trusted; 100 ns high gives ten samples here
  assign do_step     = steering_enable && (step_pin || step_reg_wr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig;
    end
  end

  always_comb begin
    fb_next = feedback_numerator;
    if (!steering_enable) begin
      fb_next = fb_base_reg;
    end else if (do_step) begin
      if (step_dec) begin
        fb_next = feedback_numerator - {2'b00, step_deviation_word};
      end else begin
        fb_next = feedback_numerator + {2'b00, step_deviation_word};
      end
    end
  end

  // register file and steered numerators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg            <= CTRL_RESET;
      step_deviation_word <= 38'h0;
      holdover_freq_word  <= 40'h0;
      fb_base_reg         <= FBNUM_RESET;
      feedback_numerator  <= FBNUM_RESET;
      anum_base_reg       <= ANUM_RESET;
      boot_seen_reg       <= 1'b0;
    end else begin
      feedback_numerator <= fb_next;
      if (boot_done && !boot_seen_reg) begin
        boot_seen_reg <= 1'b1;
        if (overlay_enable) begin
          anum_base_reg <= {36'h0, strap_page} ^ 40'hA5_0000_0000;
        end
      end
      if (wr) begin
        case (paddr)
          OFF_CTRL: begin
            ctrl_reg <= pwdata;
            if (pwdata[CTRL_STEER_EN] && state_reg != DPSDS_ST_LOCK) begin
              ctrl_reg[CTRL_STEER_EN] <= 1'b0;
            end
          end
          OFF_FDEV:    step_deviation_word[31:0]  <= pwdata;
          OFF_FDEV_HI: step_deviation_word[37:32] <= pwdata[5:0];
          OFF_FREE_LO: holdover_freq_word[31:0]   <= pwdata;
          OFF_FREE_HI: holdover_freq_word[39:32]  <= pwdata[7:0];
          OFF_FBNUM_LO: begin
            fb_base_reg[31:0]        <= pwdata;
            feedback_numerator[31:0] <= pwdata;
          end
          OFF_FBNUM_HI: begin
            fb_base_reg[39:32]        <= pwdata[7:0];
            feedback_numerator[39:32] <= pwdata[7:0];
          end
          OFF_ANUM_LO: anum_base_reg[31:0]  <= pwdata;
          OFF_ANUM_HI: anum_base_reg[39:32] <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // dpll numerator: steered when closed loop, free-run word / history in holdover, base numerator else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_dpll_num               <= FBNUM_RESET;
      effective_analog_numerator <= ANUM_RESET;
    end else begin
      if (state_reg == DPSDS_ST_HOLD) begin
        if (history_enable && history_valid) begin
          eff_dpll_num <= hist_acc_reg;
        end else begin
          eff_dpll_num <= fb_base_reg + holdover_freq_word;
        end
      end else begin
        eff_dpll_num <= closed_loop ? feedback_numerator : fb_base_reg;
      end
      if (!closed_loop) begin
        if (history_enable) begin
          effective_analog_numerator <= anum_base_reg + holdover_freq_word
                                        + (feedback_numerator - fb_base_reg);
        end else begin
          effective_analog_numerator <= anum_base_reg + holdover_freq_word;
        end
      end else begin
        effective_analog_numerator <= anum_base_reg;
      end
    end
  end

  assign stat = '{freq_lock_lost: freq_lock_lost,
                  phase_lock_lost: phase_lock_lost,
                  history_valid: history_valid,
                  wide_bw: wide_bw,
                  state: state_reg[1:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd && !penable) begin
      case (paddr)
        OFF_CTRL:     prdata <= ctrl_reg;
        OFF_STATUS:   prdata <= {22'h0, strap_page, stat};
        OFF_FDEV:     prdata <= step_deviation_word[31:0];
        OFF_FDEV_HI:  prdata <= {26'h0, step_deviation_word[37:32]};
        OFF_FREE_LO:  prdata <= holdover_freq_word[31:0];
        OFF_FREE_HI:  prdata <= {24'h0, holdover_freq_word[39:32]};
        OFF_FBNUM_LO: prdata <= feedback_numerator[31:0];
        OFF_FBNUM_HI: prdata <= {24'h0, feedback_numerator[39:32]};
        OFF_EFF_LO:   prdata <= eff_dpll_num[31:0];
        OFF_EFF_HI:   prdata <= {24'h0, eff_dpll_num[39:32]};
        OFF_ANUM_LO:  prdata <= anum_base_reg[31:0];
        OFF_ANUM_HI:  prdata <= {24'h0, anum_base_reg[39:32]};
        OFF_ENUM_LO:  prdata <= effective_analog_numerator[31:0];
        OFF_ENUM_HI:  prdata <= {24'h0, effective_analog_numerator[39:32]};
        default:      prdata <= 32'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### design/dpsds_pkg.sv
// package for the dpll state and dco steering block
// assumes apb3-style register access, single 100 MHz clock domain
package dpsds_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_FDEV      = 8'h08;
  localparam logic [7:0] OFF_FDEV_HI   = 8'h0C;
  localparam logic [7:0] OFF_FREE_LO   = 8'h10;
  localparam logic [7:0] OFF_FREE_HI   = 8'h14;
  localparam logic [7:0] OFF_FBNUM_LO  = 8'h18;
  localparam logic [7:0] OFF_FBNUM_HI  = 8'h1C;
  localparam logic [7:0] OFF_STEP      = 8'h20;
  localparam logic [7:0] OFF_EFF_LO    = 8'h24;
  localparam logic [7:0] OFF_EFF_HI    = 8'h28;
  localparam logic [7:0] OFF_ANUM_LO   = 8'h2C;
  localparam logic [7:0] OFF_ANUM_HI   = 8'h30;
  localparam logic [7:0] OFF_ENUM_LO   = 8'h34;
  localparam logic [7:0] OFF_ENUM_HI   = 8'h38;
  // ctrl field positions
  localparam int CTRL_HIST_EN   = 0;
  localparam int CTRL_STEER_EN  = 1;
  localparam int CTRL_PIN_MODE  = 2;
  localparam int CTRL_DPLL_CFG  = 3;
  localparam int CTRL_DPLL_USED = 4;
  // reset values
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0018;
  localparam logic [39:0] FBNUM_RESET = 40'h00_0000_0000;
  localparam logic [39:0] ANUM_RESET  = 40'h00_0000_0000;
  // cycle counts: acquisition, history and lock detect windows
  localparam logic [15:0] ACQ_CYCLES  = 16'h0100;
  localparam logic [15:0] HIST_CYCLES = 16'h0400;
  localparam logic [15:0] PLOCK_CYCLES = 16'h0040;
  localparam int NUM_W  = 40;
  localparam int FDEV_W = 38;

  typedef enum logic [1:0] {DPSDS_LVL_LOW, DPSDS_LVL_MID, DPSDS_LVL_HIGH,
                            DPSDS_LVL_BAD} dpsds_lvl_t;
  typedef enum {DPSDS_ST_FREE, DPSDS_ST_ACQ, DPSDS_ST_LOCK,
                DPSDS_ST_HOLD} dpsds_state_t;

  typedef struct packed {
    logic       freq_lock_lost;
    logic       phase_lock_lost;
    logic       history_valid;
    logic       wide_bw;
    logic [1:0] state;
  } dpsds_status_t;

  typedef struct packed {
    logic [3:0] page;
    logic       overlay_loaded;
    logic       apll_on_xo;
  } dpsds_boot_t;
endpackage

// ### design/dpsds_strap.sv
// three-level strap resolver with page decode
// assumes strap pins sensed as two comparator bits per pin, asynchronous
`timescale 1ns/1ps
`default_nettype none
module dpsds_strap
  import dpsds_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] strap_a_raw,
  input  wire logic [1:0] strap_b_raw,
  output logic            done,
  output logic [3:0]      page
);
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [1:0] cnt_reg;

  // comparator pair {above_high, above_low}: 00 low, 01 mid, 11 high
  function automatic dpsds_lvl_t resolve(input logic [1:0] c);
    case (c)
      2'b00:   resolve = DPSDS_LVL_LOW;
      2'b01:   resolve = DPSDS_LVL_MID;
      2'b11:   resolve = DPSDS_LVL_HIGH;
      default: resolve = DPSDS_LVL_BAD;
    endcase
  endfunction

  function automatic logic [3:0] decode(input dpsds_lvl_t b,
                                        input dpsds_lvl_t a);
    decode = 4'hF;
    if (b == DPSDS_LVL_MID && a == DPSDS_LVL_LOW) decode = 4'h5;
    if (b == DPSDS_LVL_MID && a == DPSDS_LVL_MID) decode = 4'h6;
    if (b == DPSDS_LVL_MID && a == DPSDS_LVL_HIGH) decode = 4'h7;
    if (b == DPSDS_LVL_HIGH && a == DPSDS_LVL_MID) decode = 4'h8;
    if (b == DPSDS_LVL_LOW && a == DPSDS_LVL_LOW) decode = 4'h0;
    if (b == DPSDS_LVL_LOW && a == DPSDS_LVL_HIGH) decode = 4'h1;
    if (b == DPSDS_LVL_HIGH && a == DPSDS_LVL_LOW) decode = 4'h2;
    if (b == DPSDS_LVL_HIGH && a == DPSDS_LVL_HIGH) decode = 4'h3;
    if (b == DPSDS_LVL_LOW && a == DPSDS_LVL_MID) decode = 4'h4;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {strap_b_raw, strap_a_raw};
      sync2_reg <= sync1_reg;
    end
  end

  // capture once after release, frozen until next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
      done    <= 1'b0;
      page    <= 4'h0;
    end else if (!done) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (cnt_reg == 2'h3) begin
        done <= 1'b1;
        page <= decode(resolve(sync2_reg[3:2]), resolve(sync2_reg[1:0]));
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/dpsds_asserts.sv
// concurrent checks on the dpll state and steering block ports
// assumes one pclk domain; bound onto dpsds_top below
`timescale 1ns/1ps
`default_nettype none
module dpsds_asserts
  import dpsds_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        ref_valid,
  input wire logic        wide_bw,
  input wire logic        freq_lock_lost,
  input wire logic [3:0]  boot_page,
  input wire logic [39:0] feedback_numerator
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        wr;
  logic [37:0] dev_reg;
  logic [39:0] base_reg;
  logic [8:0]  acq_reg;
  assign wr = psel && penable && pwrite;
  // shadow of deviation and base numerator, as software wrote them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_reg <= '0;
      base_reg <= FBNUM_RESET;
    end else if (wr) begin
      case (paddr)
        OFF_FDEV:     dev_reg[31:0] <= pwdata;
        OFF_FDEV_HI:  dev_reg[37:32] <= pwdata[5:0];
        OFF_FBNUM_LO: base_reg[31:0] <= pwdata;
        OFF_FBNUM_HI: base_reg[39:32] <= pwdata[7:0];
        default:      ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) acq_reg <= '0;
    else acq_reg <= wide_bw ? acq_reg + 9'h001 : 9'h000;
  end
  a_step_size: assert property (
    wr && paddr == OFF_STEP ##1 $changed(feedback_numerator) |->
    feedback_numerator == ($past(pwdata[0])
      ? $past(feedback_numerator) - {2'h0, dev_reg}
      : $past(feedback_numerator) + {2'h0, dev_reg}))
    else $error("step changed numerator by a wrong amount");
  a_steer_restore: assert property (
    wr && paddr == OFF_CTRL && !pwdata[CTRL_STEER_EN] |->
    ##[1:2] feedback_numerator == base_reg)
    else $error("numerator not restored after steering off");
  a_acq_bound: assert property (acq_reg <= ACQ_CYCLES)
    else $error("wide bandwidth held too long");
  a_acq_cause: assert property (
    $rose(wide_bw) |-> $past(ref_valid, 2) || $past(ref_valid, 3)
    || $past(ref_valid, 4))
    else $error("acquisition without a valid reference");
  a_page_hold: assert property (
    boot_page != 4'h0 |=> $stable(boot_page))
    else $error("start-up page changed after boot");
  a_page_legal: assert property (
    boot_page <= 4'h8 || boot_page == 4'hF)
    else $error("start-up page out of range");
  a_fll_frozen: assert property (
    !ref_valid [*4] |=> !$fell(freq_lock_lost))
    else $error("frequency lock flag fell with no reference");
  a_bad_addr: assert property (
    psel && penable && (paddr > OFF_ENUM_HI || paddr[1:0] != 2'h0)
    |-> pslverr)
    else $error("unmapped access without error");
  c_step: cover property (wr && paddr == OFF_STEP);
  c_acq: cover property ($fell(wide_bw));
  c_err: cover property (pslverr);
endmodule
bind dpsds_top dpsds_asserts chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pslverr, .ref_valid, .wide_bw,
  .freq_lock_lost, .boot_page, .feedback_numerator);
`default_nettype wire

// ### sim/dpsds_far.sv
// far-side model: reference qualifiers and step/direction pins
// assumes bench commands change just after pclk edges
`timescale 1ns/1ps
`default_nettype none
module dpsds_far (
  input  wire logic pclk,
  input  wire logic ref_on,
  input  wire logic step_go,
  input  wire logic step_dir,
  output logic      ref_valid,
  output logic      freq_in_tol,
  output logic      phase_in_tol,
  output logic      freq_step_up,
  output logic      freq_step_down
);
  logic [4:0] cnt_reg = 5'h00;
  logic       dir_reg = 1'b0;
  // a lost reference takes both tolerance levels with it
  always_ff @(posedge pclk) begin
    ref_valid <= ref_on;
    freq_in_tol <= ref_on;
    phase_in_tol <= ref_on;
  end
  // 120 ns high, at least 130 ns low: pulse wide enough, rate under 5 MHz
  always_ff @(posedge pclk) begin
    if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
    else if (step_go) begin
      cnt_reg <= 5'h18;
      dir_reg <= step_dir;
    end
  end
  assign freq_step_up = cnt_reg > 5'h0C;
  assign freq_step_down = dir_reg;
endmodule
`default_nettype wire

// ### sim/dpsds_top_bench.sv
// self-checking bench for dpsds_top
// assumes 100 MHz pclk and the far-side model on references and pins
`timescale 1ns/1ps
`default_nettype none
module dpsds_top_bench;
  import dpsds_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } dpsds_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, overlay_enable = 1'b0;
  logic        xo_valid = 1'b1, ref_on = 1'b0, step_go = 1'b0;
  logic        step_dir = 1'b0;
  logic [1:0]  page_strap_a = 2'h0, page_strap_b = 2'h0;
  logic        ref_valid, freq_in_tol, phase_in_tol;
  logic        freq_step_up, freq_step_down, freq_lock_lost;
  logic        phase_lock_lost, wide_bw, apll_on_xo;
  logic [3:0]  boot_page;
  logic [39:0] feedback_numerator, eff_dpll_num;
  logic [7:0]  pages [4] = '{8'h45, 8'h56, 8'h77, 8'hD8};
  dpsds_row_t  rows [10] = '{
    '{OFF_FDEV, 32'h10, 32'h10}, '{OFF_FDEV_HI, 32'hFFFFFFFF, 32'h3F},
    '{OFF_FDEV_HI, 32'h0, 32'h0}, '{OFF_FREE_HI, 32'hFFFFFFFF, 32'hFF},
    '{OFF_FREE_HI, 32'h0, 32'h0}, '{OFF_FREE_LO, 32'h5, 32'h5},
    '{OFF_FBNUM_LO, 32'h10000000, 32'h10000000},
    '{OFF_FBNUM_HI, 32'h0, 32'h0}, '{OFF_CTRL, 32'h19, 32'h19},
    '{8'h3C, 32'hDEADBEEF, 32'h0}};
  int          bad_count = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  dpsds_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .page_strap_a, .page_strap_b,
    .overlay_enable, .xo_valid, .ref_valid, .freq_in_tol, .phase_in_tol,
    .freq_step_up, .freq_step_down, .freq_lock_lost, .phase_lock_lost,
    .wide_bw, .apll_on_xo, .boot_page, .eff_dpll_num,
    .feedback_numerator);
  dpsds_far far (.pclk, .ref_on, .step_go, .step_dir, .ref_valid,
    .freq_in_tol, .phase_in_tol, .freq_step_up, .freq_step_down);
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t register read %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t output %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wait_bw(input logic v);
    for (int i = 0; i < 400; i++) begin
      @(posedge pclk);
      if (wide_bw === v) return;
    end
    chk_pin({39'h0, wide_bw}, {39'h0, v});
  endtask
  task automatic boot(input logic [1:0] a, input logic [1:0] b,
                      input logic ov);
    @(posedge pclk);
    presetn <= 1'b0;
    page_strap_a <= a;
    page_strap_b <= b;
    overlay_enable <= ov;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge pclk);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(pages[i][5:4], pages[i][7:6], i[0]);
      chk_pin({36'h0, boot_page}, {36'h0, pages[i][3:0]});
      chk_pin({38'h0, freq_lock_lost, phase_lock_lost}, 40'h3);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk_reg(rd, CTRL_RESET);
      apb(1'b0, OFF_ANUM_LO, 32'h0);
      chk_pin({39'h0, rd != 32'h0}, {39'h0, i[0]});
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk_reg(rd, rows[i].e);
      chk_pin({39'h0, err}, {39'h0, rows[i].a == 8'h3C});
    end
    apb(1'b1, OFF_CTRL, 32'h11);
    chk_pin({39'h0, apll_on_xo}, 40'h1);
    xo_valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_pin({39'h0, apll_on_xo}, 40'h0);
    xo_valid <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h19);
    ref_on <= 1'b1;
    wait_bw(1'b1);
    wait_bw(1'b0);
    repeat (PLOCK_CYCLES + 16) @(posedge pclk);
    chk_pin({38'h0, freq_lock_lost, phase_lock_lost}, 40'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_reg({30'h0, rd[1:0]}, 32'h2);
    apb(1'b1, OFF_CTRL, 32'h1B);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_STEP, {31'h0, i != 0});
      @(posedge pclk);
      chk_pin(feedback_numerator, 40'h10000010 - 40'(16 * i));
    end
    apb(1'b1, OFF_CTRL, 32'h1F);
    apb(1'b1, OFF_STEP, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      step_dir <= i[0];
      step_go <= 1'b1;
      @(posedge pclk);
      step_go <= 1'b0;
      repeat (30) @(posedge pclk);
      chk_pin(feedback_numerator, 40'h10000000 - 40'(16 * i));
    end
    apb(1'b1, OFF_CTRL, 32'h19);
    repeat (2) @(posedge pclk);
    chk_pin(feedback_numerator, 40'h10000000);
    repeat (HIST_CYCLES + 16) @(posedge pclk);
    ref_on <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_reg({26'h0, rd[5:0]}, 32'h1B);
    chk_pin({4'h0, eff_dpll_num[39:4]}, 40'h1000000);
    ref_on <= 1'b1;
    wait_bw(1'b1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
